/* File: src/hall_ctrl_pkg.sv */
/*
  Package for the host-side Hall sensor conditioner that drives a three-phase
  commutation driver through its Hall channel and direction pins.
  Assumes one 200 MHz clock, synchronous active-low reset, sensors already
  synchronous to clk.
*/
// Notes on behaviour
// - Each Hall input is high while a rotor window covers its sensor.
// - Sensor pattern matches two 90 degree windows 180 apart, sensors 30 apart.
// - Forward: input two rises 30 degrees after one, three 30 after two.
// - Unmatched motors get sensors remapped and inverted until the pattern fits.
// - Example motor: sensor c to one, inverted a to two, b to three.
// - Inversion uses the negative input with the positive tied to reference.
`default_nettype none
package hall_ctrl_pkg;
  localparam int          HALL_CH        = 3;
  // Sensor routing select per Hall channel: which motor sensor feeds it
  localparam logic [1:0]  SEL_SENSOR_A   = 2'h0;
  localparam logic [1:0]  SEL_SENSOR_B   = 2'h1;
  localparam logic [1:0]  SEL_SENSOR_C   = 2'h2;
  // Example motor mapping, applied while use_reset_map is high
  localparam logic [5:0]  MAP_RESET      = {SEL_SENSOR_B, SEL_SENSOR_A, SEL_SENSOR_C};
  localparam logic [2:0]  INV_RESET      = 3'h2;
  localparam logic        DIR_FORWARD    = 1'h0;
  localparam logic        DIR_REVERSE    = 1'h1;
  localparam logic [2:0]  CODE_BAD_A     = 3'h2;
  localparam logic [2:0]  CODE_BAD_B     = 3'h5;
  // Least time a reversal request stays pending before it is applied
  localparam int          DIR_HOLD_NS    = 100;
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          DIR_HOLD_CYC   = (DIR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  DIR_HOLD_LAST  = 8'(DIR_HOLD_CYC - 1);
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_BRAKE = 2'b01,
    ST_TURN  = 2'b10
  } dir_state_t;
endpackage
`default_nettype wire

/* File: src/hall_route_lane.sv */
/*
  One Hall channel of the sensor router: picks a motor sensor and presents it
  to the driver's differential pair, inverting by swapping pins.
  Assumes sensors are synchronous logic levels.
*/
`default_nettype none
module hall_route_lane (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [2:0]  sensors,
  input  wire logic [1:0]  sel,
  input  wire logic        invert,
  output logic             pos_r,
  output logic             neg_r,
  output logic             level_r
);
  logic picked;

  always_comb begin
    case (sel)
      hall_ctrl_pkg::SEL_SENSOR_A: picked = sensors[0];
      hall_ctrl_pkg::SEL_SENSOR_B: picked = sensors[1];
      hall_ctrl_pkg::SEL_SENSOR_C: picked = sensors[2];
      default:                     picked = 1'b0;
    endcase
  end

  // No inverter gate: an inverted sensor goes to the negative pin
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pos_r   <= 1'b0;
      neg_r   <= 1'b0;
      level_r <= 1'b0;
    end else begin
      pos_r   <= invert ? 1'b0 : picked;
      neg_r   <= invert ? picked : 1'b0;
      level_r <= picked ^ invert;
    end
  end
endmodule
`default_nettype wire

/* File: src/hall_commutation_decoder.sv */
/*
  Host-side controller for a three-phase commutation driver: routes motor
  sensors onto the three Hall differential pairs, drives the direction
  select with a safe reversal sequence, and watches the driver's speed pulse
  and thermal state.
  Assumes sensors, speed pulse and over-temperature flag are synchronous.
*/
`default_nettype none
module hall_commutation_decoder (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        motor_sensor_a,
  input  wire logic        motor_sensor_b,
  input  wire logic        motor_sensor_c,
  input  wire logic [5:0]  sensor_map,
  input  wire logic [2:0]  sensor_invert,
  input  wire logic        use_reset_map,
  input  wire logic        direction_request,
  input  wire logic        speed_pulse_in,
  input  wire logic        over_temp,
  output logic [2:0]       hall_pos_r,
  output logic [2:0]       hall_neg_r,
  output logic             rotation_direction_select_r,
  output logic             drive_enable_r,
  output logic             rotation_tick_r,
  output logic             code_invalid_r,
  output logic             sequence_error_r,
  output logic [2:0]       expected_high_r,
  output logic [2:0]       expected_low_r
);
  logic [2:0]                    sensors;
  logic [2:0]                    hall_level;
  logic [5:0]                    map_use;
  logic [2:0]                    inv_use;
  logic [2:0]                    prev_code_r;
  logic                          speed_prev_r;
  logic [7:0]                    hold_cnt_r;
  hall_ctrl_pkg::dir_state_t     dir_state_r;
  logic [2:0]                    up_nxt;
  logic [2:0]                    lo_nxt;
  logic [2:0]                    next_fwd;
  logic [2:0]                    next_prev;

  assign sensors = {motor_sensor_c, motor_sensor_b, motor_sensor_a};
  assign map_use = use_reset_map ? hall_ctrl_pkg::MAP_RESET : sensor_map;
  assign inv_use = use_reset_map ? hall_ctrl_pkg::INV_RESET : sensor_invert;

  // Lane 0 is Hall input one; every lane is high while its window covers it
  genvar g;
  generate
    for (g = 0; g < hall_ctrl_pkg::HALL_CH; g++) begin : g_lane
      hall_route_lane u_lane (
        .clk     (clk),
        .rstn    (rstn),
        .sensors (sensors),
        .sel     (map_use[2*g+1:2*g]),
        .invert  (inv_use[g]),
        .pos_r   (hall_pos_r[g]),
        .neg_r   (hall_neg_r[g]),
        .level_r (hall_level[g])
      );
    end
  endgenerate

  // Code as the driver resolves it, Hall one as the most significant bit
  logic [2:0] code;
  assign code = {hall_level[0], hall_level[1], hall_level[2]};

  // Forward successor in the six-step order 100,110,111,011,001,000
  // An invalid code is its own successor, so any step into or out of one is flagged
  function automatic logic [2:0] fwd_succ(input logic [2:0] c);
    case (c)
      3'h4:    fwd_succ = 3'h6;
      3'h6:    fwd_succ = 3'h7;
      3'h7:    fwd_succ = 3'h3;
      3'h3:    fwd_succ = 3'h1;
      3'h1:    fwd_succ = 3'h0;
      3'h0:    fwd_succ = 3'h4;
      default: fwd_succ = c;
    endcase
  endfunction

  assign next_fwd  = fwd_succ(code);
  assign next_prev = fwd_succ(prev_code_r);

  // Model of the driver's switch pattern, used to supervise it
  always_comb begin
    case (code)
      3'h4:    begin up_nxt = 3'h1; lo_nxt = 3'h4; end
      3'h6:    begin up_nxt = 3'h2; lo_nxt = 3'h4; end
      3'h7:    begin up_nxt = 3'h2; lo_nxt = 3'h1; end
      3'h3:    begin up_nxt = 3'h4; lo_nxt = 3'h1; end
      3'h1:    begin up_nxt = 3'h4; lo_nxt = 3'h2; end
      3'h0:    begin up_nxt = 3'h1; lo_nxt = 3'h2; end
      default: begin up_nxt = 3'h0; lo_nxt = 3'h0; end
    endcase
  end

  // One phase undriven in each step floats; never both switches of a phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      expected_high_r <= 3'h0;
      expected_low_r  <= 3'h0;
    end else if (!drive_enable_r) begin
      expected_high_r <= 3'h0;
      expected_low_r  <= 3'h0;
    end else if (rotation_direction_select_r == hall_ctrl_pkg::DIR_REVERSE) begin
      expected_high_r <= lo_nxt;
      expected_low_r  <= up_nxt;
    end else begin
      expected_high_r <= up_nxt;
      expected_low_r  <= lo_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      code_invalid_r <= 1'b0;
    end else begin
      code_invalid_r <= (code == hall_ctrl_pkg::CODE_BAD_A) ||
                        (code == hall_ctrl_pkg::CODE_BAD_B);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_code_r <= 3'h0;
    end else begin
      prev_code_r <= code;
    end
  end

  // A step to neither neighbour flags a sensor map fault; direction is not
  // checked, since the motor may coast backwards through a reversal
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sequence_error_r <= 1'b0;
    end else if (code != prev_code_r) begin
      sequence_error_r <= (next_prev != code) && (next_fwd != prev_code_r);
    end else begin
      sequence_error_r <= 1'b0;
    end
  end

  // Direction changes only after a short brake so the bridge settles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dir_state_r <= hall_ctrl_pkg::ST_RUN;
    end else begin
      case (dir_state_r)
        hall_ctrl_pkg::ST_RUN: begin
          if (direction_request != rotation_direction_select_r) begin
            dir_state_r <= hall_ctrl_pkg::ST_BRAKE;
          end
        end
        hall_ctrl_pkg::ST_BRAKE: begin
          if (direction_request == rotation_direction_select_r) begin
            dir_state_r <= hall_ctrl_pkg::ST_RUN;
          end else if (hold_cnt_r == hall_ctrl_pkg::DIR_HOLD_LAST) begin
            dir_state_r <= hall_ctrl_pkg::ST_TURN;
          end
        end
        hall_ctrl_pkg::ST_TURN: begin
          dir_state_r <= hall_ctrl_pkg::ST_RUN;
        end
        default: begin
          dir_state_r <= hall_ctrl_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Brake time counter; cleared outside the brake so every reversal waits in full
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_cnt_r <= 8'h00;
    end else if (dir_state_r != hall_ctrl_pkg::ST_BRAKE) begin
      hold_cnt_r <= 8'h00;
    end else if (hold_cnt_r != hall_ctrl_pkg::DIR_HOLD_LAST) begin
      hold_cnt_r <= hold_cnt_r + 8'h01;
    end
  end

  // The pin moves only from the turn state, when the bridge is already off
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rotation_direction_select_r <= hall_ctrl_pkg::DIR_FORWARD;
    end else if (dir_state_r == hall_ctrl_pkg::ST_TURN) begin
      rotation_direction_select_r <= direction_request;
    end
  end

  // Outputs are held off while braking or while the driver reports overheat
  always_ff @(posedge clk) begin
    if (!rstn) begin
      drive_enable_r <= 1'b0;
    end else begin
      drive_enable_r <= !over_temp && (dir_state_r == hall_ctrl_pkg::ST_RUN);
    end
  end

  // Previous level resets low, so a speed pulse already high when reset ends gives one tick
  always_ff @(posedge clk) begin
    if (!rstn) begin
      speed_prev_r <= 1'b0;
    end else begin
      speed_prev_r <= speed_pulse_in;
    end
  end

  // Rising edge of the speed pulse marks one electrical rotation
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rotation_tick_r <= 1'b0;
    end else begin
      rotation_tick_r <= speed_pulse_in && !speed_prev_r;
    end
  end
endmodule
`default_nettype wire

/* File: dv/hall_commutation_decoder_checker.sv */
/* Port checker for the Hall sensor conditioner.
   Assumes one clock and a synchronous active-low reset. */
`default_nettype none
module hall_commutation_decoder_checker (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       speed_pulse_in,
  input wire logic       over_temp,
  input wire logic [2:0] hall_pos_r,
  input wire logic [2:0] hall_neg_r,
  input wire logic       rotation_direction_select_r,
  input wire logic       drive_enable_r,
  input wire logic       rotation_tick_r,
  input wire logic       code_invalid_r,
  input wire logic [2:0] expected_high_r,
  input wire logic [2:0] expected_low_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_tick_on_rise: assert property ($rose(speed_pulse_in) |=> rotation_tick_r)
    else $error("no tick after speed pulse rise");
  chk_tick_cause: assert property (rotation_tick_r |-> $past(speed_pulse_in) &&
    !$past(speed_pulse_in, 2)) else $error("tick without a rise");
  chk_no_shoot: assert property ((expected_high_r & expected_low_r) == 3'h0)
    else $error("upper and lower of one phase on");
  chk_phase_float: assert property ($countones(expected_high_r) <= 1 &&
    $countones(expected_high_r) == $countones(expected_low_r)) else $error("no floating phase");
  chk_invalid_off: assert property (code_invalid_r |-> {expected_high_r, expected_low_r} == 6'h00)
    else $error("switch on for invalid code");
  chk_hot_disable: assert property (over_temp |=> !drive_enable_r)
    else $error("drive enabled while hot");
  chk_hot_quiet: assert property (over_temp [*2] |=> expected_high_r == 3'h0)
    else $error("upper switch on while hot");
  chk_lane_excl: assert property ((hall_pos_r & hall_neg_r) == 3'h0)
    else $error("both pins of a lane driven");
  chk_dir_while_off: assert property ($changed(rotation_direction_select_r) |-> !drive_enable_r)
    else $error("direction changed while driving");
  cover property (rotation_tick_r);
  cover property ($changed(rotation_direction_select_r));
  cover property (code_invalid_r);
endmodule
`default_nettype wire

/* File: dv/hall_driver_model.sv */
/* Behavioural commutation driver: Hall channels, direction, speed pulse, thermal cut-out.
   Assumes 0 on a pin tied to reference; ref_on_pos gives the board wiring. */
`default_nettype none
module hall_driver_model (
  input  wire logic [2:0] hall_pos,
  input  wire logic [2:0] hall_neg,
  input  wire logic [2:0] ref_on_pos,
  input  wire logic       dir_sel,
  input  wire logic [7:0] temp_c,
  output logic [2:0]      upper,
  output logic [2:0]      lower,
  output logic            speed_pulse,
  output logic            over_temp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ch;
  logic [5:0] ul;
  always_comb begin
    for (int g = 0; g < 3; g++) ch[g] = ref_on_pos[g] ? ~hall_neg[g] : hall_pos[g];
    case ({ch[0], ch[1], ch[2]})
      3'h4: ul = {3'h1, 3'h4};
      3'h6: ul = {3'h2, 3'h4};
      3'h7: ul = {3'h2, 3'h1};
      3'h3: ul = {3'h4, 3'h1};
      3'h1: ul = {3'h4, 3'h2};
      3'h0: ul = {3'h1, 3'h2};
      default: ul = 6'h00;
    endcase
    if (over_temp) ul = 6'h00;
    upper = dir_sel ? ul[2:0] : ul[5:3];
    lower = dir_sel ? ul[5:3] : ul[2:0];
  end
  // Open collector in silicon; modelled as a plain level
  assign speed_pulse = ch[0];
  initial over_temp = 1'b0;
  always @(temp_c) begin
    if (temp_c >= 8'h96) over_temp = 1'b1;
    else if (temp_c <= 8'h78) over_temp = 1'b0;
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
/* Self-checking bench for the Hall sensor conditioner driving a driver model.
   Assumes the package, design, model and checker are compiled first. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk  = 1'b0;
  logic       rstn = 1'b0;
  logic       sa   = 1'b0;
  logic       sb   = 1'b0;
  logic       sc   = 1'b0;
  logic       ur   = 1'b1;
  logic       dreq = 1'b0;
  logic [5:0] map  = 6'h00;
  logic [2:0] inv  = 3'h0;
  logic [7:0] temp = 8'h19;
  logic [2:0] hp, hn, eh, el, up, lo, wr;
  logic       dir, den, tick, bad, spd, hot, serr;
  int         serrs = 0;
  int         bad_count = 0;
  int         checks = 0;
  int         ticks = 0;
  int         cyc = 0;
  int         seed = 20876;
  logic [2:0] fwd [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  logic [7:0] tlist [3] = '{8'h96, 8'h82, 8'h78};
  // Example motor board ties the positive pin of lane 1, Hall input two, to reference
  assign wr = ur ? 3'h2 : inv;
  hall_commutation_decoder hall_commutation_decoder_inst (
    .clk(clk), .rstn(rstn), .motor_sensor_a(sa), .motor_sensor_b(sb),
    .motor_sensor_c(sc), .sensor_map(map), .sensor_invert(inv), .use_reset_map(ur),
    .direction_request(dreq), .speed_pulse_in(spd), .over_temp(hot),
    .hall_pos_r(hp), .hall_neg_r(hn), .rotation_direction_select_r(dir),
    .drive_enable_r(den), .rotation_tick_r(tick), .code_invalid_r(bad),
    .sequence_error_r(serr), .expected_high_r(eh), .expected_low_r(el));
  hall_driver_model hall_driver_model_inst (
    .hall_pos(hp), .hall_neg(hn), .ref_on_pos(wr), .dir_sel(dir), .temp_c(temp),
    .upper(up), .lower(lo), .speed_pulse(spd), .over_temp(hot));
  always #2.5 clk = ~clk;
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (serr === 1'b1) serrs <= serrs + 1;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sensors {c,b,a} of the example motor that give Hall code k
  function automatic logic [2:0] sens_of(input logic [2:0] k);
    sens_of = {k[2], k[0], ~k[1]};
  endfunction
  function automatic logic [2:0] lanes(input logic [2:0] s, input logic [5:0] m,
                                       input logic [2:0] v);
    for (int g = 0; g < 3; g++) lanes[g] = (m[2*g+:2] == 2'h3 ? 1'b0 : s[m[2*g+:2]]) ^ v[g];
  endfunction
  task automatic step(input logic [2:0] s);
    logic [2:0] w;
    logic [2:0] k;
    {sc, sb, sa} = s;
    repeat (3) @(posedge clk);
    #1 w = ur ? {s[1], ~s[0], s[2]} : lanes(s, map, inv);
    k = {w[0], w[1], w[2]};
    cmp(8'((wr & ~hn) | (~wr & hp)), 8'(w));
    cmp(8'({eh, el}), 8'({up, lo}));
    cmp(8'(bad), 8'(k == 3'h2 || k == 3'h5));
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1 cmp(8'({dir, den}), 8'h01);
    for (int r = 0; r < 12; r++) step(sens_of(fwd[r % 6]));
    cmp(8'(ticks), 8'h02);
    // Reset code 010 sits between two steps that leave the six-step ring
    cmp(8'(serrs), 8'h02);
    $display("test forward rotation done");
    step(sens_of(3'h2));
    step(sens_of(3'h5));
    $display("test invalid codes done");
    dreq = 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp(8'(den), 8'h00);
    repeat (40) @(posedge clk);
    #1 cmp(8'({dir, den}), 8'h03);
    for (int r = 0; r < 6; r++) step(sens_of(fwd[5 - r]));
    // 000 to 010, 010 to 101 and 101 to 000 are off the ring; reverse steps are not
    cmp(8'(serrs), 8'h05);
    $display("test reverse done");
    for (int i = 0; i < 3; i++) begin
      temp = tlist[i];
      step(sens_of(fwd[i]));
      cmp(8'(den), 8'(i / 2));
    end
    $display("test thermal done");
    ur = 1'b0;
    for (int i = 0; i < 40; i++) begin
      map = 6'($random(seed));
      inv = 3'($random(seed));
      step(3'($random(seed)));
    end
    $display("test random map done");
    final_report();
  end
endmodule
bind hall_commutation_decoder hall_commutation_decoder_checker hall_commutation_decoder_checker_inst (.*);
`default_nettype wire
